// ---- verilog/brd_pkg.sv ----
// Package for the boot remap address decoder.
// Assumes a single master clock domain; all users reference names with brd_pkg::.
package brd_pkg;
    // Bank decode
    localparam int          BANK_MSB       = 31;
    localparam int          BANK_LSB       = 28;
    localparam logic [3:0]  BANK_INTERNAL  = 4'h0;
    localparam logic [3:0]  BANK_EXT_FIRST = 4'h1;
    localparam logic [3:0]  BANK_EXT_LAST  = 4'h6;
    localparam logic [3:0]  BANK_DDR       = 4'h7;
    localparam logic [3:0]  BANK_PERIPH    = 4'hf;
    // Internal area decode, 1 Mbyte regions inside bank 0
    localparam int          REGION_MSB     = 27;
    localparam int          REGION_LSB     = 20;
    localparam logic [7:0]  REG_BOOT       = 8'h00;
    localparam logic [7:0]  REG_INSTR_TCM  = 8'h01;
    localparam logic [7:0]  REG_DATA_TCM   = 8'h02;
    localparam logic [7:0]  REG_SRAM       = 8'h03;
    localparam logic [7:0]  REG_ROM        = 8'h04;
    // SRAM: four 16 Kbyte blocks, 64 Kbyte total
    localparam int          SRAM_BLOCKS    = 4;
    localparam int          SRAM_BLK_AW    = 14;
    localparam int          SRAM_AW        = 16;
    localparam logic [31:0] SRAM_BASE      = 32'h0030_0000;
    localparam logic [31:0] ROM_BASE       = 32'h0040_0000;
    localparam logic [31:0] BOOT_LAST      = 32'h000f_ffff;
    // External bus: 26 address bits per chip select
    localparam int          EXT_AW         = 26;
    localparam int          EXT_CS_NUM     = 6;
    // Reset state of static controller when booting externally
    localparam logic        SMC_BYTE_SEL_RST = 1'b1;
    localparam logic [1:0]  SMC_WIDTH_16     = 2'h1;
    localparam logic        SMC_RW_BY_CS_RST = 1'b1;
    // SRAM split options
    typedef enum logic [1:0] {
        BRD_SPLIT_GP   = 2'h0,
        BRD_SPLIT_DATA_TIGHT_MEM = 2'h1,
        BRD_SPLIT_HALF = 2'h2
    } brd_split_t;
    // Decoded targets, one-hot
    typedef enum logic [7:0] {
        BRD_T_NONE = 8'h01,
        BRD_T_EXT  = 8'h02,
        BRD_T_DDR  = 8'h04,
        BRD_T_SRAM = 8'h08,
        BRD_T_ROM  = 8'h10,
        BRD_T_PER  = 8'h20,
        BRD_T_ERR  = 8'h40
    } brd_target_t;
    // Access phase, one-hot
    typedef enum logic [2:0] {
        BRD_S_IDLE = 3'h1,
        BRD_S_WAIT = 3'h2,
        BRD_S_DONE = 3'h4
    } brd_state_t;
endpackage : brd_pkg

// ---- verilog/brd_sram.sv ----
// Internal SRAM model: 64 Kbyte as four 16 Kbyte blocks behind one port.
// Assumes word writes with byte enables; read data registered.
`timescale 1ns/1ns
module brd_sram #(
    parameter int AW = brd_pkg::SRAM_AW
) (
    input  wire logic          clk,     // Master clock
    input  wire logic          ce,      // Clock enable
    input  wire logic          en,      // Access strobe
    input  wire logic          we,      // Write
    input  wire logic [3:0]    be,      // Byte enables
    input  wire logic [AW-1:0] addr,    // Byte address
    input  wire logic [31:0]   wdata,   // Write data
    output logic      [31:0]   rdata    // Registered read data
);
    logic [31:0] mem [0:(1<<(AW-2))-1];

    // Word array with byte lanes
    always_ff @(posedge clk) begin
        if (ce && en) begin
            for (int i = 0; i < 4; i++) begin
                if (we && be[i]) mem[addr[AW-1:2]][8*i +: 8] <= wdata[8*i +: 8];
            end
            rdata <= mem[addr[AW-1:2]];
        end
    end
endmodule : brd_sram

// ---- verilog/brd_decoder.sv ----
// Boot remap address decoder with internal SRAM and tight-memory wait option.
// Assumes one master at a time presents req with addr; peripherals answer outside.
`timescale 1ns/1ns
module brd_decoder #(
    parameter int EXT_AW = brd_pkg::EXT_AW
) (
    input  wire logic               clk,                // Master clock
    input  wire logic               rst_n,              // Async reset, active low
    input  wire logic               ce,                 // Clock enable
    input  wire logic               boot_source_pin,    // Boot select pin
    input  wire logic               remap_cmd,          // Remap command pulse
    input  wire logic               tight_mem_wait_bit, // Wait state enable
    input  wire logic [1:0]         sram_split,         // SRAM split option
    input  wire logic               cs1_sdram_sel,      // CS1 to SDRAM controller
    input  wire logic               cs3_nand_en,        // NAND on CS3
    input  wire logic               cs45_card_en,       // Card on CS4/CS5
    input  wire logic               req,                // Access request
    input  wire logic               proc_master,        // Requester is processor
    input  wire logic               tcm_side,           // Access on tight port
    input  wire logic               we,                 // Write
    input  wire logic [3:0]         be,                 // Byte enables
    input  wire logic [31:0]        addr,               // Address
    input  wire logic [31:0]        wdata,              // Write data
    output logic                    ready,              // Access done pulse
    output logic                    error,              // Error response pulse
    output logic      [31:0]        rdata,              // SRAM read data
    output logic      [5:0]         ext_cs_n,           // External chip selects
    output logic      [EXT_AW-1:0]  ext_addr,           // External address
    output logic                    ddr_chip_select,    // DDR select
    output logic                    sdram_chip_select,  // SDRAM select on CS1
    output logic                    nand_sel,           // NAND on CS3
    output logic                    card_sel,           // Card on CS4/CS5
    output logic                    rom_sel,            // ROM select
    output logic      [15:0]        rom_addr,           // ROM offset
    output logic                    periph_sel,         // Peripheral bridge
    output logic                    remap_state,        // Remap done
    output logic                    boot_from_rom,      // Latched boot choice
    output logic                    smc_byte_sel,       // Static ctrl byte select
    output logic      [1:0]         smc_width,          // Static ctrl width
    output logic                    smc_rw_by_cs        // Strobes by chip select
);
    initial begin
        if (EXT_AW < 1 || EXT_AW > 26) $error("EXT_AW out of range");
    end

    logic [2:0] pin_sync_r;
    logic [2:0] fill_r;
    logic       boot_rom_r, boot_rom_nxt, boot_seen_r;
    logic       remap_r;
    brd_pkg::brd_state_t  state_r, state_nxt;
    brd_pkg::brd_target_t tgt_r, tgt_nxt;
    logic [3:0]  ext_idx_r;
    logic [31:0] addr_r;

    // Bank and region fields
    wire  [3:0] bank   = addr[brd_pkg::BANK_MSB:brd_pkg::BANK_LSB];
    wire  [7:0] region = addr[brd_pkg::REGION_MSB:brd_pkg::REGION_LSB];
    wire        is_int = bank == brd_pkg::BANK_INTERNAL;
    wire        is_ext = bank >= brd_pkg::BANK_EXT_FIRST && bank <= brd_pkg::BANK_EXT_LAST;
    wire        is_ddr = bank == brd_pkg::BANK_DDR;
    wire        is_per = bank == brd_pkg::BANK_PERIPH;
    wire [15:0] ofs    = addr[15:0];
    wire        in_half  = ofs[15] == 1'b0;

    // Split: which SRAM aliases are backed
    function automatic logic alias_ok(input logic [7:0] r, input logic [1:0] s,
                                      input logic lo);
        logic ok;
        ok = 1'b0;
        unique case (r)
            brd_pkg::REG_INSTR_TCM: ok = (s == brd_pkg::BRD_SPLIT_HALF) && lo;
            brd_pkg::REG_DATA_TCM:  ok = (s == brd_pkg::BRD_SPLIT_DATA_TIGHT_MEM) ||
                                         ((s == brd_pkg::BRD_SPLIT_HALF) && lo);
            brd_pkg::REG_SRAM:      ok = s == brd_pkg::BRD_SPLIT_GP;
            default:                ok = 1'b0;
        endcase
        return ok;
    endfunction : alias_ok

    // Physical SRAM offset: data half lives above instruction half
    wire [15:0] sram_phys = (region == brd_pkg::REG_DATA_TCM &&
                             sram_split == brd_pkg::BRD_SPLIT_HALF) ?
                            {1'b1, ofs[14:0]} : ofs;

    // Boot alias target
    wire zero_sram = remap_r && proc_master && sram_split == brd_pkg::BRD_SPLIT_GP;
    wire zero_rom  = !remap_r && boot_rom_r;
    wire zero_ext  = !remap_r && !boot_rom_r;
    wire int_sram  = alias_ok(region, sram_split, in_half);
    wire int_rom   = region == brd_pkg::REG_ROM && ofs == addr[15:0]
                     && addr[19:16] == 4'h0;
    wire sram_hit  = is_int && ((region == brd_pkg::REG_BOOT && zero_sram) || int_sram);
    wire rom_hit   = is_int && ((region == brd_pkg::REG_BOOT && zero_rom) || int_rom);
    wire boot_ext  = is_int && region == brd_pkg::REG_BOOT && zero_ext;

    // Target select
    always_comb begin
        if (is_ext || boot_ext) tgt_nxt = brd_pkg::BRD_T_EXT;
        else if (is_ddr)        tgt_nxt = brd_pkg::BRD_T_DDR;
        else if (is_per)        tgt_nxt = brd_pkg::BRD_T_PER;
        else if (sram_hit)      tgt_nxt = brd_pkg::BRD_T_SRAM;
        else if (rom_hit)       tgt_nxt = brd_pkg::BRD_T_ROM;
        else                    tgt_nxt = brd_pkg::BRD_T_ERR;
    end

    // External chip select index; boot alias goes to zero
    wire [3:0] ext_idx_nxt = boot_ext ? 4'h0 : bank - 4'h1;

    // Boot pin: three-stage sync, caught once after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pin_sync_r <= 3'h0;
        else if (ce) pin_sync_r <= {pin_sync_r[1:0], boot_source_pin};
    end

    // Marks sync stages that hold a real pin sample, not reset zeros
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) fill_r <= 3'h0;
        else if (ce) fill_r <= {fill_r[1:0], 1'b1};
    end

    // Reset zeros in both stages must not count as an agreed pin level
    wire pin_agree = fill_r[2] && (pin_sync_r[1] == pin_sync_r[2]);
    assign boot_rom_nxt = boot_seen_r ? boot_rom_r : pin_sync_r[2];

    // Boot choice latched from hardware only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_rom_r  <= 1'b0;
            boot_seen_r <= 1'b0;
        end else if (ce && !boot_seen_r && pin_agree) begin
            boot_rom_r  <= boot_rom_nxt;
            boot_seen_r <= 1'b1;
        end
    end

    // Remap state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) remap_r <= 1'b0;
        else if (ce && remap_cmd) remap_r <= 1'b1;
    end

    // Access sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            brd_pkg::BRD_S_IDLE:
                if (req && boot_seen_r)
                    state_nxt = (tight_mem_wait_bit && tcm_side &&
                                 tgt_nxt == brd_pkg::BRD_T_SRAM) ?
                                brd_pkg::BRD_S_WAIT : brd_pkg::BRD_S_DONE;
            brd_pkg::BRD_S_WAIT: state_nxt = brd_pkg::BRD_S_DONE;
            brd_pkg::BRD_S_DONE: state_nxt = brd_pkg::BRD_S_IDLE;
            default:             state_nxt = brd_pkg::BRD_S_IDLE;
        endcase
    end

    wire take = state_r == brd_pkg::BRD_S_IDLE && req && boot_seen_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= brd_pkg::BRD_S_IDLE;
            tgt_r     <= brd_pkg::BRD_T_NONE;
            ext_idx_r <= 4'h0;
            addr_r    <= 32'h0;
        end else if (ce) begin
            state_r <= state_nxt;
            if (take) begin
                tgt_r     <= tgt_nxt;
                ext_idx_r <= ext_idx_nxt;
                addr_r    <= addr;
            end else if (state_r == brd_pkg::BRD_S_DONE) begin
                tgt_r <= brd_pkg::BRD_T_NONE;
            end
        end
    end

    // SRAM behind one port
    brd_sram #(.AW(brd_pkg::SRAM_AW)) u_sram (
        .clk   (clk),
        .ce    (ce),
        .en    (take && tgt_nxt == brd_pkg::BRD_T_SRAM),
        .we    (we),
        .be    (be),
        .addr  (sram_phys),
        .wdata (wdata),
        .rdata (rdata)
    );

    // Outputs
    wire active = state_r != brd_pkg::BRD_S_IDLE;
    wire ext_on = active && tgt_r == brd_pkg::BRD_T_EXT;
    assign ready        = state_r == brd_pkg::BRD_S_DONE && tgt_r != brd_pkg::BRD_T_ERR;
    assign error        = state_r == brd_pkg::BRD_S_DONE && tgt_r == brd_pkg::BRD_T_ERR;
    assign ext_cs_n     = ext_on ? ~(6'h01 << ext_idx_r[2:0]) : 6'h3f;
    assign ext_addr     = addr_r[EXT_AW-1:0];
    assign ddr_chip_select   = active && tgt_r == brd_pkg::BRD_T_DDR;
    assign sdram_chip_select = ext_on && ext_idx_r == 4'h1 && cs1_sdram_sel;
    assign nand_sel     = ext_on && ext_idx_r == 4'h3 && cs3_nand_en;
    assign card_sel     = ext_on && (ext_idx_r == 4'h4 || ext_idx_r == 4'h5)
                          && cs45_card_en;
    assign rom_sel      = active && tgt_r == brd_pkg::BRD_T_ROM;
    assign rom_addr     = addr_r[15:0];
    assign periph_sel   = active && tgt_r == brd_pkg::BRD_T_PER;
    assign remap_state  = remap_r;
    assign boot_from_rom = boot_rom_r;
    assign smc_byte_sel = brd_pkg::SMC_BYTE_SEL_RST;
    assign smc_width    = brd_pkg::SMC_WIDTH_16;
    assign smc_rw_by_cs = brd_pkg::SMC_RW_BY_CS_RST;

    // Checks
    ddr_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && addr[31:28] == 4'h7 |=> ddr_chip_select) else $error("ddr miss");
    ext_cs_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && addr[31:28] == 4'h3 |=> ext_cs_n == 6'h3b) else $error("cs bad");
    per_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && addr[31:28] == 4'hf |=> periph_sel) else $error("periph miss");
    unused_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && addr[31:28] == 4'h9 |=> error) else $error("no abort");
    wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && tcm_side && tight_mem_wait_bit && tgt_nxt == brd_pkg::BRD_T_SRAM
        |=> !ready ##1 (ready || !ce)) else $error("wait bad");
    remap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        remap_r |=> remap_r) else $error("remap lost");
    rom_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && addr[31:16] == 16'h0040 |=> rom_sel) else $error("rom miss");
    boot_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && !remap_r && !boot_rom_r && addr[31:20] == 12'h000
        |=> ext_cs_n == 6'h3e) else $error("boot cs0 miss");
    boot_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        boot_seen_r |=> $stable(boot_rom_r) && boot_seen_r) else $error("boot moved");
    boot_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fill_r[2] |-> !boot_seen_r) else $error("boot early");
endmodule : brd_decoder

// ---- tb/brd_master.sv ----
// Bus master model: one request at a time, held until the answer is sampled.
// Assumes the decoder answers with ready or error; released address, data and write show inverted values.
`timescale 1ns/1ns
module brd_master (
    input  wire logic        clk,         // Master clock
    input  wire logic        ready,       // Access done pulse
    input  wire logic        error,       // Error response pulse
    output logic             req,         // Access request
    output logic             proc_master, // Requester is processor
    output logic             tcm_side,    // Access on tight port
    output logic             we,          // Write
    output logic [3:0]       be,          // Byte enables
    output logic [31:0]      addr,        // Address
    output logic [31:0]      wdata        // Write data
);
    // Idle bus at time zero
    initial begin
        req = 1'b0;
        proc_master = 1'b0;
        tcm_side = 1'b0;
        we = 1'b0;
        be = 4'h0;
        addr = 32'h0;
        wdata = 32'h0;
    end

    // One access; n counts falling edges from take to answer
    task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d,
                          input logic pm, input logic ts, output int n);
        @(negedge clk);
        req = 1'b1;
        addr = a;
        we = w;
        wdata = d;
        be = 4'hf;
        proc_master = pm;
        tcm_side = ts;
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(ready === 1'b1 || error === 1'b1) && n < 16);
        @(posedge clk);
        @(negedge clk);
        req = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
        we = ~we;
    endtask : access
endmodule : brd_master

// ---- tb/brd_decoder_tb.sv ----
// Self-checking bench for the boot remap address decoder.
// Assumes the master model drives requests; answers checked from a queue of notes.
`timescale 1ns/1ns
module brd_decoder_tb;
    logic        clk, rst_n, ce, pin, remap_cmd, wait_bit, o1, o3, o45;
    logic [1:0]  split;
    logic        req, pm, ts, we, ready, error, ddr, sd, nand_s, card, rom, per, rmp, bfr;
    logic        sbs, srw;
    logic [1:0]  swd;
    logic [3:0]  be;
    logic [31:0] addr, wdata, rdata;
    logic [5:0]  cs_n;
    logic [25:0] ext_addr;
    logic [15:0] rom_addr;
    logic [46:0] exp_q[$];
    logic [46:0] e;
    logic [31:0] d[4];
    int          fails, checks_done, cycles, lat, lat0, seed;

    // Clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    brd_master i_brd_master (.clk(clk), .ready(ready), .error(error), .req(req),
        .proc_master(pm), .tcm_side(ts), .we(we), .be(be), .addr(addr), .wdata(wdata));

    brd_decoder i_brd_decoder (.clk(clk), .rst_n(rst_n), .ce(ce), .boot_source_pin(pin),
        .remap_cmd(remap_cmd), .tight_mem_wait_bit(wait_bit), .sram_split(split),
        .cs1_sdram_sel(o1), .cs3_nand_en(o3), .cs45_card_en(o45), .req(req),
        .proc_master(pm), .tcm_side(ts), .we(we), .be(be), .addr(addr), .wdata(wdata),
        .ready(ready), .error(error), .rdata(rdata), .ext_cs_n(cs_n), .ext_addr(ext_addr),
        .ddr_chip_select(ddr), .sdram_chip_select(sd), .nand_sel(nand_s), .card_sel(card),
        .rom_sel(rom), .rom_addr(rom_addr), .periph_sel(per), .remap_state(rmp),
        .boot_from_rom(bfr), .smc_byte_sel(sbs), .smc_width(swd), .smc_rw_by_cs(srw));

    // Verdict and end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // Plain value comparison
    task automatic cmp_val(input logic [31:0] act, input logic [31:0] exp);
        checks_done++;
        if (act !== exp) begin
            fails++;
            $display("ERROR t=%0t got %h expected %h", $time, act, exp);
        end
    endtask : cmp_val

    // Answer comparison: selects, then read data or external address by kind
    task automatic cmp_resp(input logic [46:0] n, input logic [12:0] sel);
        cmp_val({19'h0, sel}, {19'h0, n[44:32]});
        if (n[46:45] == 2'h1)
            cmp_val(rdata, n[31:0]);
        if (n[46:45] == 2'h2)
            cmp_val({6'h0, ext_addr}, n[31:0]);
    endtask : cmp_resp

    // Note the expectation, then let the master run the access
    task automatic run(input logic [31:0] a, input logic w, input logic [31:0] dv,
                       input logic p, input logic t, input logic [1:0] k,
                       input logic [12:0] s, input logic [31:0] v);
        exp_q.push_back({k, s, v});
        i_brd_master.access(a, w, dv, p, t, lat);
    endtask : run

    // Reset values after a release
    task automatic chk_rst(input logic p);
        cmp_val({26'h0, cs_n}, 32'h3f);
        cmp_val({31'h0, rmp}, 32'h0);
        cmp_val({31'h0, bfr}, {31'h0, p});
        cmp_val({28'h0, srw, sbs, swd}, {28'h0, 1'b1, 1'b1, brd_pkg::SMC_WIDTH_16});
    endtask : chk_rst

    // Oldest note compared whenever an answer shows
    always @(negedge clk) begin
        if (ready === 1'b1 || error === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("ERROR t=%0t unexpected answer %h", $time, {ready, error});
            end else begin
                e = exp_q.pop_front();
                cmp_resp(e, {error, ddr, rom, per, sd, nand_s, card, cs_n});
            end
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            stop_test;
        end
    end

    initial begin
        seed = 32'h0c61;
        {rst_n, remap_cmd, wait_bit, o1, o3, o45, split} = '0;
        {ce, pin} = 2'h3;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk_rst(1'b1);
        // Boot alias on ROM, ROM at its own base
        run(32'h0000_0100, 0, 0, 1, 0, 2'h0, 13'h043f, 0);
        run(brd_pkg::ROM_BASE, 0, 0, 0, 0, 2'h0, 13'h043f, 0);
        $display("test boot done");
        // Banks 1 to 15, options off then on
        for (int o = 0; o < 2; o++) begin
            @(negedge clk);
            {o1, o3, o45} = {3{o[0]}};
            for (int b = 1; b < 16; b++) begin
                e[31:0] = {6'h0, 26'($random(seed))};
                e[44:32] = (b == 7) ? 13'h083f : (b == 15) ? 13'h023f : 13'h103f;
                if (b <= 6)
                    e[44:32] = {o[0] && b == 2, o[0] && b == 4, o[0] && b >= 5,
                                ~(6'h1 << (b - 1))};
                run({b[3:0], 2'h0, e[25:0]}, 0, 0, 1, 0, b <= 6 ? 2'h2 : 2'h0,
                    e[44:32], e[31:0]);
            end
        end
        $display("test banks done");
        // One word in each SRAM block, then read back
        for (int k = 0; k < 4; k++) begin
            d[k] = $random(seed);
            run(brd_pkg::SRAM_BASE + k * 32'h4000 + 4, 1, d[k], 0, 0, 2'h0, 13'h003f, 0);
        end
        for (int k = 0; k < 4; k++)
            run(brd_pkg::SRAM_BASE + k * 32'h4000 + 4, 0, 0, 0, 0, 2'h1, 13'h003f, d[k]);
        run(32'h0010_0000, 0, 0, 1, 0, 2'h0, 13'h103f, 0);
        $display("test sram done");
        // Remap puts general SRAM at zero for the processor only
        @(negedge clk);
        remap_cmd = 1'b1;
        @(negedge clk);
        remap_cmd = 1'b0;
        @(negedge clk);
        cmp_val({31'h0, rmp}, 32'h1);
        run(32'h4, 0, 0, 1, 0, 2'h1, 13'h003f, d[0]);
        run(32'h4, 0, 0, 0, 0, 2'h0, 13'h103f, 0);
        run(brd_pkg::ROM_BASE, 0, 0, 1, 0, 2'h0, 13'h043f, 0);
        $display("test remap done");
        // Tight-memory splits and the extra wait state
        @(negedge clk);
        split = 2'h1;
        run(32'h0020_0010, 1, d[1], 1, 1, 2'h0, 13'h003f, 0);
        run(32'h0020_0010, 0, 0, 1, 1, 2'h1, 13'h003f, d[1]);
        lat0 = lat;
        wait_bit = 1'b1;
        run(32'h0020_0010, 0, 0, 1, 1, 2'h1, 13'h003f, d[1]);
        cmp_val(32'(lat), 32'(lat0 + 1));
        run(32'h0030_0000, 0, 0, 1, 0, 2'h0, 13'h103f, 0);
        split = 2'h2;
        run(32'h0010_0020, 1, d[2], 1, 0, 2'h0, 13'h003f, 0);
        run(32'h0010_0020, 0, 0, 1, 0, 2'h1, 13'h003f, d[2]);
        $display("test tcm done");
        // Second reset with the pin low: boot alias on chip select zero
        rst_n = 1'b0;
        pin = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk_rst(1'b0);
        run(32'h0000_0040, 0, 0, 1, 0, 2'h2, 13'h003e, 32'h40);
        $display("test extboot done");
        stop_test;
    end
endmodule : brd_decoder_tb
